// ---- cl_out_pkg.sv ----
package cl_out_pkg;
  // pixel and tap geometry
  localparam int PIX_W       = 16;
  localparam int TAP_W       = 8;
  localparam int TAP_COUNT   = 3;
  localparam int LINK_W      = TAP_W * TAP_COUNT;
  localparam int RGN_W       = 12;

  // crossing word layout: {eof, eol, sof, pixel}
  localparam int WORD_SOF    = PIX_W;
  localparam int WORD_EOL    = PIX_W + 1;
  localparam int WORD_EOF    = PIX_W + 2;
  localparam int WORD_W      = PIX_W + 3;

  // link mode values
  localparam logic LINK_MODE_OFF = 1'h0;
  localparam logic LINK_MODE_ON  = 1'h1;

  // clock rates
  localparam int CLK_KHZ      = 50000;
  localparam int LINK_CLK_KHZ = 40000;

  // exposure end to frame valid rise, in ns
  localparam int FIRE_TO_FVAL_NS  = 494400;
  // multiply before dividing so the fractional microsecond is not lost
  localparam int FIRE_TO_FVAL_CYC = FIRE_TO_FVAL_NS * (CLK_KHZ / 1000) / 1000;
  localparam int DLY_W            = 16;

  // reset values
  localparam logic [1:0] PACK_CNT_RST = 2'h0;
endpackage : cl_out_pkg

// ---- pix_buf2.sv ----
module pix_buf2 #(
  parameter int W     = 19,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          push;
  logic          pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem_r[rd_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  // ready and valid are flops; ready looks one push ahead, so a word offered
  // while ready is high always has room, and ready stays low during reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      in_ready  <= cnt_nxt != CW'(DEPTH);
      out_valid <= cnt_nxt != '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule : pix_buf2

// ---- cl_pixel_stream_output.sv ----
// Overview of operation
// - the block only transmits on the link and has no serial control channel at all.
// - the link is a base configuration of three byte taps clocked by the 40 MHz pixel clock.
// - each pixel is a 16-bit unsigned value sent low byte first.
// - the link takes the processed stream at the same point that feeds the USB buffer.
// - only region pixels are sent, so line and frame valid follow region width and height.
// - a mode value of 0 turns the link off and 1 turns it on.
// - control stays elsewhere and the USB copy of the stream keeps flowing in parallel.
// - USB request timing has no influence on when link words go out.
// - the exposure indicator follows each exposure, registered one system clock late.
// - frame valid rises about 494.4 us after the exposure indicator falls.
module cl_pixel_stream_output
  import cl_out_pkg::*;
#(
  parameter int FVAL_DELAY_CYC = cl_out_pkg::FIRE_TO_FVAL_CYC,
  parameter int BUF_DEPTH      = 2
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         link_clk,
  input  wire logic                         set_link_output_mode,
  input  wire logic [cl_out_pkg::RGN_W-1:0] region_of_interest_width,
  input  wire logic [cl_out_pkg::RGN_W-1:0] region_of_interest_height,
  input  wire logic                         exposure_active,
  input  wire logic                         pix_valid,
  input  wire logic [cl_out_pkg::PIX_W-1:0] pix_data,
  output logic                              pix_ready,
  output logic                              usb_valid,
  output logic [cl_out_pkg::PIX_W-1:0]      usb_data,
  output logic                              fire_out,
  output logic                              link_fval,
  output logic                              link_lval,
  output logic                              link_dval,
  output logic [cl_out_pkg::LINK_W-1:0]     link_data
);
  import cl_out_pkg::*;

  // capture side, system clock
  logic              accept;
  logic [RGN_W-1:0]  col_r;
  logic [RGN_W-1:0]  row_r;
  logic              at_sof;
  logic              at_eol;
  logic              at_eof;
  logic              mode_r;
  logic              frame_on;
  logic [WORD_W-1:0] cap_word;
  logic              buf_in_valid;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic              buf_out_ready;
  logic [WORD_W-1:0] buf_out_data;
  logic [DLY_W-1:0]  dly_r;
  logic              exp_fall;

  // crossing
  logic              req_r;
  logic [WORD_W-1:0] xfer_r;
  logic              ack_s1_r;
  logic              ack_s2_r;
  logic              pending;
  logic              launch;

  // link side
  logic              lrst_s1_r;
  logic              lrst_s2_r;
  logic              req_s1_r;
  logic              req_s2_r;
  logic              ack_r;
  logic              lk_new;
  logic [PIX_W-1:0]  lk_pix;
  logic [PIX_W-1:0]  acc_r;
  logic [1:0]        cnt_r;
  logic              flush_r;
  logic              eof_r;

  // pixels are only taken when the link buffer has room, so a stalled link
  // holds the processing pipe instead of dropping words
  assign accept = pix_valid && pix_ready;
  assign at_sof = (col_r == '0) && (row_r == '0);
  assign at_eol = col_r == region_of_interest_width - RGN_W'(1);
  assign at_eof = at_eol && (row_r == region_of_interest_height - RGN_W'(1));

  // mode takes effect only at a frame start so a half frame never reaches the grabber
  assign frame_on     = at_sof ? (set_link_output_mode == LINK_MODE_ON) : mode_r;
  assign buf_in_valid = accept && frame_on;
  assign cap_word     = {at_eof, at_eol, at_sof, pix_data};

  // the buffer's own ready flop already looks one push ahead; a further
  // registered copy would lag by a cycle and let a word into a full buffer
  assign pix_ready = buf_in_ready;

  // raster position inside the region
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      col_r <= '0;
      row_r <= '0;
    end else if (accept) begin
      if (at_eol) begin
        col_r <= '0;
        row_r <= at_eof ? '0 : row_r + RGN_W'(1);
      end else begin
        col_r <= col_r + RGN_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= LINK_MODE_OFF;
    end else if (accept && at_sof) begin
      mode_r <= set_link_output_mode;
    end
  end

  // usb copy is taken at the very same acceptance as the link copy,
  // so both paths see identical processed pixels
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      usb_valid <= 1'b0;
      usb_data  <= '0;
    end else begin
      usb_valid <= accept;
      usb_data  <= pix_data;
    end
  end

  // exposure indicator and the frame transfer hold-off that follows it
  assign exp_fall = fire_out && !exposure_active;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fire_out <= 1'b0;
    end else begin
      fire_out <= exposure_active;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dly_r <= '0;
    end else if (exp_fall) begin
      dly_r <= DLY_W'(FVAL_DELAY_CYC);
    end else if (dly_r != '0) begin
      dly_r <= dly_r - DLY_W'(1);
    end
  end

  pix_buf2 #(
    .W     (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (buf_in_valid),
    .in_data   (cap_word),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (buf_out_ready)
  );

  // a frame start word waits out the transfer delay; nothing from the usb
  // side enters this decision, so its jitter cannot move link timing
  assign pending       = req_r != ack_s2_r;
  assign launch        = buf_out_valid && !pending && (!buf_out_data[WORD_SOF] || dly_r == '0);
  assign buf_out_ready = launch;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_r  <= 1'b0;
      xfer_r <= '0;
    end else if (launch) begin
      req_r  <= ~req_r;
      xfer_r <= buf_out_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  // link side reset: asserted at once, released on the link clock
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lrst_s1_r <= 1'b1;
      lrst_s2_r <= 1'b1;
    end else begin
      lrst_s1_r <= 1'b0;
      lrst_s2_r <= lrst_s1_r;
    end
  end

  always_ff @(posedge link_clk or posedge lrst_s2_r) begin
    if (lrst_s2_r) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
    end
  end

  // a word is taken only when the line flush is done; xfer_r is stable
  // from the toggle until the ack returns
  assign lk_new = (req_s2_r != ack_r) && !flush_r;
  assign lk_pix = xfer_r[PIX_W-1:0];

  always_ff @(posedge link_clk or posedge lrst_s2_r) begin
    if (lrst_s2_r) begin
      ack_r <= 1'b0;
    end else if (lk_new) begin
      ack_r <= req_s2_r;
    end
  end

  // byte packer: pixel bytes go low first into tap A, then B, then C;
  // a row whose byte count is not a multiple of three ends in a padded word
  always_ff @(posedge link_clk or posedge lrst_s2_r) begin
    if (lrst_s2_r) begin
      acc_r     <= '0;
      cnt_r     <= PACK_CNT_RST;
      link_dval <= 1'b0;
      link_data <= '0;
    end else if (lk_new) begin
      case (cnt_r)
        2'h0: begin
          acc_r     <= lk_pix;
          cnt_r     <= 2'h2;
          link_dval <= 1'b0;
        end
        2'h2: begin
          link_data <= {lk_pix[TAP_W-1:0], acc_r[PIX_W-1:TAP_W], acc_r[TAP_W-1:0]};
          acc_r     <= {{TAP_W{1'b0}}, lk_pix[PIX_W-1:TAP_W]};
          cnt_r     <= 2'h1;
          link_dval <= 1'b1;
        end
        2'h1: begin
          link_data <= {lk_pix, acc_r[TAP_W-1:0]};
          cnt_r     <= 2'h0;
          link_dval <= 1'b1;
        end
        default: begin
          cnt_r     <= PACK_CNT_RST;
          link_dval <= 1'b0;
        end
      endcase
    end else if (flush_r && cnt_r != PACK_CNT_RST) begin
      link_data <= {{(LINK_W - PIX_W){1'b0}}, acc_r};
      cnt_r     <= PACK_CNT_RST;
      link_dval <= 1'b1;
    end else begin
      link_dval <= 1'b0;
    end
  end

  // line and frame framing
  always_ff @(posedge link_clk or posedge lrst_s2_r) begin
    if (lrst_s2_r) begin
      link_fval <= 1'b0;
      link_lval <= 1'b0;
      flush_r   <= 1'b0;
      eof_r     <= 1'b0;
    end else if (lk_new) begin
      if (xfer_r[WORD_SOF]) begin
        link_fval <= 1'b1;
      end
      link_lval <= 1'b1;
      flush_r   <= xfer_r[WORD_EOL];
      eof_r     <= xfer_r[WORD_EOF];
    end else if (flush_r && cnt_r == PACK_CNT_RST) begin
      link_lval <= 1'b0;
      flush_r   <= 1'b0;
      if (eof_r) begin
        link_fval <= 1'b0;
      end
    end
  end

  // words only reach the packer from frames whose mode was on at their
  // first pixel, so every packed word belongs to an open frame

  // transmit only: there is no serial control receiver and no command port
endmodule : cl_pixel_stream_output

// ---- cl_out_props.sv ----
module cl_out_props #(
  parameter int FVAL_DELAY_CYC = 20
) (
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire logic                         link_clk,
  input wire logic                         exposure_active,
  input wire logic                         pix_valid,
  input wire logic [cl_out_pkg::PIX_W-1:0] pix_data,
  input wire logic                         pix_ready,
  input wire logic                         usb_valid,
  input wire logic [cl_out_pkg::PIX_W-1:0] usb_data,
  input wire logic                         fire_out,
  input wire logic                         link_fval,
  input wire logic                         link_lval,
  input wire logic                         link_dval
);
  import cl_out_pkg::*;
  int unsigned since_fire_r;

  // saturating count of clk cycles since the exposure indicator last fell
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) since_fire_r <= 0;
    else if (fire_out) since_fire_r <= 0;
    else if (since_fire_r < FVAL_DELAY_CYC) since_fire_r <= since_fire_r + 1;
  end

  sequence take_s;
    pix_valid && pix_ready;
  endsequence
  sequence row_open_s;
    $rose(link_lval);
  endsequence
  sequence row_close_s;
    $fell(link_lval);
  endsequence

  chk_usb_copy: assert property (@(posedge clk) disable iff (sys_rst)
    take_s |=> usb_valid && usb_data == $past(pix_data)) else $error("usb copy wrong");
  chk_usb_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !(pix_valid && pix_ready) |=> !usb_valid) else $error("usb pulse without take");
  chk_fire_level: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> fire_out == $past(exposure_active)) else $error("fire not following");
  chk_fval_delay: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(link_fval) |-> since_fire_r >= FVAL_DELAY_CYC) else $error("fval too early");
  chk_lval_in_fval: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_lval |-> link_fval) else $error("lval outside fval");
  chk_dval_in_lval: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_dval |-> link_lval) else $error("dval outside lval");
  chk_frame_open: assert property (@(posedge link_clk) disable iff (sys_rst)
    $rose(link_fval) |-> row_open_s) else $error("frame opens without row");
  chk_frame_close: assert property (@(posedge link_clk) disable iff (sys_rst)
    $fell(link_fval) |-> row_close_s) else $error("frame closes off row end");
endmodule : cl_out_props

bind cl_pixel_stream_output cl_out_props #(.FVAL_DELAY_CYC(FVAL_DELAY_CYC)) u_props (
  .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .exposure_active(exposure_active),
  .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
  .usb_valid(usb_valid), .usb_data(usb_data), .fire_out(fire_out),
  .link_fval(link_fval), .link_lval(link_lval), .link_dval(link_dval));

// ---- cl_grabber_model.sv ----
module cl_grabber_model (
  input wire logic                          link_clk,
  input wire logic [cl_out_pkg::RGN_W-1:0]  width,
  input wire logic                          fval,
  input wire logic                          lval,
  input wire logic                          dval,
  input wire logic [cl_out_pkg::LINK_W-1:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  import cl_out_pkg::*;
  logic [7:0]       row_b[$];
  logic [PIX_W-1:0] pix_q[$];
  int               rows = 0;
  int               frames = 0;
  logic             lval_r = 1'b0;
  logic             fval_r = 1'b0;

  always @(posedge link_clk) begin
    if (lval && dval) begin
      row_b.push_back(data[7:0]);
      row_b.push_back(data[15:8]);
      row_b.push_back(data[23:16]);
    end
    // bytes past the region width are padding and dropped
    if (lval_r && !lval) begin
      for (int i = 0; i < 2 * width; i += 2) begin
        pix_q.push_back({row_b[i + 1], row_b[i]});
      end
      rows++;
      row_b.delete();
    end
    if (fval_r && !fval) frames++;
    lval_r <= lval;
    fval_r <= fval;
  end
endmodule : cl_grabber_model

// ---- tb_cl_pixel_stream_output.sv ----
module tb_cl_pixel_stream_output;
  timeunit 1ns;
  timeprecision 1ps;
  import cl_out_pkg::*;
  logic             clk, link_clk, sys_rst, mode, expo, pix_valid, pix_ready;
  logic             usb_valid, fire_out, fval, lval, dval;
  logic [RGN_W-1:0] width, height;
  logic [PIX_W-1:0] pix_data, usb_data, exp_q[$];
  logic [LINK_W-1:0] ldata;
  int               bad_count = 0;
  int               cmp_count = 0;
  int               seed = 91979;

  cl_pixel_stream_output #(.FVAL_DELAY_CYC(20), .BUF_DEPTH(2)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .set_link_output_mode(mode),
    .region_of_interest_width(width), .region_of_interest_height(height),
    .exposure_active(expo), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_ready(pix_ready), .usb_valid(usb_valid), .usb_data(usb_data),
    .fire_out(fire_out), .link_fval(fval), .link_lval(lval), .link_dval(dval),
    .link_data(ldata));
  cl_grabber_model u_fg (.link_clk(link_clk), .width(width), .fval(fval), .lval(lval),
    .dval(dval), .data(ldata));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    link_clk = 0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      bad_count++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : ck

  task results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // valid only rises at a negedge where ready is seen, so no stale pixel is retaken
  task put(input logic [PIX_W-1:0] d, input bit gap, inout bit stall);
    int n;
    n = 0;
    if (gap || !pix_ready) begin
      stall |= !gap;
      pix_valid = 0;
      do begin
        @(negedge clk);
        n++;
      end while (!pix_ready && n < 5000);
    end
    pix_valid = 1;
    pix_data = d;
    @(negedge clk);
    ck("usb_valid", 1, usb_valid);
    ck("usb_data", d, usb_data);
  endtask : put

  task run_frame(input logic [RGN_W-1:0] w, input logic [RGN_W-1:0] h, input logic m);
    logic [PIX_W-1:0] d;
    int f0, r0, n;
    bit stall;
    f0 = u_fg.frames;
    r0 = u_fg.rows;
    stall = 0;
    width = w;
    height = h;
    mode = m;
    expo = 1;
    repeat (4) @(negedge clk);
    ck("fire_out", 1, fire_out);
    expo = 0;
    for (int i = 0; i < w * h; i++) begin
      d = (i % 7 == 0) ? 16'hff00 : 16'($random(seed));
      if (m) exp_q.push_back(d);
      put(d, i > 2 && $random(seed) % 4 == 0, stall);
    end
    pix_valid = 0;
    n = 0;
    while (m && u_fg.frames == f0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (!m) repeat (200) @(negedge clk);
    if (m && w * h >= 4) ck("refused", 1, stall);
    ck("frames", m, u_fg.frames - f0);
    ck("rows", m ? h : 0, u_fg.rows - r0);
    while (u_fg.pix_q.size() > 0) ck("pixel", exp_q.pop_front(), u_fg.pix_q.pop_front());
    ck("missing", 0, exp_q.size());
    $display("frame %0dx%0d mode %0d done", w, h, m);
  endtask : run_frame

  initial begin
    sys_rst = 1;
    mode = 0;
    expo = 0;
    pix_valid = 0;
    pix_data = 0;
    width = 1;
    height = 1;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    repeat (2) @(negedge clk);
    run_frame(1, 1, 1);
    run_frame(5, 3, 1);
    run_frame(4, 2, 0);
    for (int k = 0; k < 4; k++) begin
      run_frame(12'(1 + $unsigned($random(seed)) % 12), 12'(1 + $unsigned($random(seed)) % 4), 1);
    end
    results();
  end

  initial begin
    #1500000;
    bad_count++;
    results();
  end
endmodule : tb_cl_pixel_stream_output
